// [rtl/ptp_announce_traceability_select.sv]
// Purpose: grandmaster announce flag selection, timebase epoch, delay replies
// Assumes: inputs synchronous to clk_sys; cfg_update is a one-cycle pulse
// Notes: no software registers; configuration arrives as a struct port
//
// Overview of operation
// - arbitrary mode aligns the timebase to the supplied source epoch, taken as arbitrary
// - non-TAI event timestamps carry arbitrary-timescale values
// - arbitrary and frequency modes clear the PTP timescale flag
// - both non-TAI modes clear leap59, leap61 and timeTraceable
// - both non-TAI modes set frequencyTraceable and mark UTC offset invalid
// - arbitrary mode: configured timeSource; clockClass configured, default 13
// - frequency mode: timeSource internal oscillator, clockClass configured with or without profile_en
// - frequency mode runs its own epoch, advanced at reference rate
// - frequency mode slave offset keeps the path delay in
// - as master, every delay request on our sub-domain gets a matching delay response
// - another master on our sub-domain forces the passive state
// - one configured sub-domain governs delay requests and rival announce detection
// - configured static asymmetry is removed from the slave offset
// - correction-field asymmetry is removed from the slave offset
// - TAI mode sets timescale and traceable flags, clockClass default 6
`timescale 1ns/10ps
module ptp_announce_traceability_select #(
    parameter int unsigned PASSIVE_CYCLES = ptp_announce_pkg::PASSIVE_HOLD_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire ptp_announce_pkg::cfg_t cfg_in,
    input wire logic cfg_update,
    input wire logic ref_tick,
    input wire logic epoch_load,
    input wire ptp_announce_pkg::ts_t epoch_val,
    input wire logic foreign_ann_valid,
    input wire logic [7:0] foreign_domain,
    input wire logic dreq_valid,
    input wire logic [7:0] dreq_domain,
    input wire logic [15:0] dreq_seq,
    input wire logic offset_req,
    input wire logic signed [31:0] sync_delta_ns,
    input wire logic signed [31:0] path_delay_ns,
    input wire logic signed [31:0] corr_asym_ns,
    output ptp_announce_pkg::ann_t ann_q,
    output logic [7:0] domain_q,
    output logic passive_q,
    output ptp_announce_pkg::ts_t event_ts_q,
    output logic ts_arb_q,
    output logic dresp_valid_q,
    output logic [15:0] dresp_seq_q,
    output ptp_announce_pkg::ts_t dresp_ts_q,
    output logic offset_valid_q,
    output logic signed [31:0] offset_ns_q
);

    typedef enum logic [1:0] {
        ST_INIT,
        ST_MASTER,
        ST_PASSIVE
    } gm_state_t;

    // one place for all announce field selection so no field can lag another
    function automatic ptp_announce_pkg::ann_t pick_fields(input ptp_announce_pkg::cfg_t c);
        ptp_announce_pkg::ann_t a;
        a.utc_offset = c.utc_offset;
        a.time_source = c.time_source;
        a.clock_class = c.clock_class;
        case (c.mode)
            ptp_announce_pkg::MODE_TAI: begin
                a.ptp_timescale = 1'b1;
                a.time_traceable = 1'b1;
                a.freq_traceable = 1'b1;
                a.utc_valid = 1'b1;
                a.leap59 = c.leap59;
                a.leap61 = c.leap61;
                if (!c.profile_en) begin
                    a.clock_class = ptp_announce_pkg::CLASS_TAI_DEFAULT;
                end
            end
            default: begin
                a.ptp_timescale = 1'b0;
                a.leap59 = 1'b0;
                a.leap61 = 1'b0;
                a.time_traceable = 1'b0;
                a.freq_traceable = 1'b1;
                a.utc_valid = 1'b0;
                if (c.mode == ptp_announce_pkg::MODE_FREQ) begin
                    a.time_source = ptp_announce_pkg::SRC_INTERNAL_OSC;
                end else if (!c.profile_en) begin
                    a.clock_class = ptp_announce_pkg::CLASS_ARB_DEFAULT;
                end
            end
        endcase
        return a;
    endfunction

    // path delay is only subtracted where phase matters
    function automatic logic signed [31:0] slave_offset(
        input logic freq_only,
        input logic signed [31:0] delta,
        input logic signed [31:0] pdel,
        input logic signed [31:0] s_asym,
        input logic signed [31:0] c_asym
    );
        logic signed [31:0] r;
        r = delta - s_asym - c_asym;
        if (!freq_only) begin
            r = r - pdel;
        end
        return r;
    endfunction

    // configuration and announce group
    ptp_announce_pkg::cfg_t cfg_q, cfg_d;
    ptp_announce_pkg::ann_t ann_d;
    logic [7:0] domain_d;

    always_comb begin
        cfg_d = cfg_q;
        ann_d = ann_q;
        domain_d = domain_q;
        if (cfg_update) begin
            cfg_d = cfg_in;
            ann_d = pick_fields(cfg_in);
            domain_d = cfg_in.domain;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= '{mode: ptp_announce_pkg::MODE_FREQ,
                       ref_step_ns: ptp_announce_pkg::REF_STEP_RESET,
                       domain: ptp_announce_pkg::DOMAIN_RESET,
                       default: '0};
            ann_q <= '{freq_traceable: 1'b1,
                       time_source: ptp_announce_pkg::SRC_INTERNAL_OSC,
                       default: '0};
            domain_q <= ptp_announce_pkg::DOMAIN_RESET;
        end else begin
            cfg_q <= cfg_d;
            ann_q <= ann_d;
            domain_q <= domain_d;
        end
    end

    wire logic freq_mode = (cfg_q.mode == ptp_announce_pkg::MODE_FREQ);

    // timebase group
    ptp_announce_pkg::ts_t tb_now;
    logic tb_load;
    logic ts_arb_d;
    ptp_announce_pkg::ts_t event_ts_d;

    // frequency mode ignores supplied epochs: it keeps its own
    assign tb_load = epoch_load && !freq_mode;

    timebase_counter u_timebase (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ref_tick(ref_tick),
        .step_ns(cfg_q.ref_step_ns),
        .load(tb_load),
        .load_val(epoch_val),
        .tb_q(tb_now)
    );

    always_comb begin
        event_ts_d = tb_now;
        ts_arb_d = (cfg_q.mode != ptp_announce_pkg::MODE_TAI);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            event_ts_q <= '0;
            ts_arb_q <= 1'b1;
        end else begin
            event_ts_q <= event_ts_d;
            ts_arb_q <= ts_arb_d;
        end
    end

    // master / passive group
    gm_state_t state_q, state_d;
    logic [31:0] quiet_q, quiet_d;
    logic passive_d;
    logic rival_seen;

    assign rival_seen = foreign_ann_valid && (foreign_domain == domain_q);

    always_comb begin
        state_d = state_q;
        quiet_d = quiet_q;
        case (state_q)
            ST_INIT: begin
                state_d = ST_MASTER;
                quiet_d = '0;
            end
            ST_MASTER: begin
                if (rival_seen) begin
                    state_d = ST_PASSIVE;
                    quiet_d = '0;
                end
            end
            ST_PASSIVE: begin
                if (rival_seen) begin
                    quiet_d = '0;
                end else if (quiet_q >= PASSIVE_CYCLES - 1) begin
                    state_d = ST_MASTER;
                    quiet_d = '0;
                end else begin
                    quiet_d = quiet_q + 32'h0000_0001;
                end
            end
            default: begin
                state_d = ST_INIT;
                quiet_d = '0;
            end
        endcase
        // a new sub-domain makes any earlier conflict irrelevant
        if (cfg_update && cfg_in.domain != domain_q) begin
            state_d = ST_INIT;
        end
        passive_d = (state_d == ST_PASSIVE);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_INIT;
            quiet_q <= '0;
            passive_q <= 1'b0;
        end else begin
            state_q <= state_d;
            quiet_q <= quiet_d;
            passive_q <= passive_d;
        end
    end

    // delay response group: one reply per accepted request, no queue needed
    logic dreq_take;
    logic dresp_valid_d;
    logic [15:0] dresp_seq_d;
    ptp_announce_pkg::ts_t dresp_ts_d;

    assign dreq_take = dreq_valid && (state_q == ST_MASTER) && (dreq_domain == domain_q);

    always_comb begin
        dresp_valid_d = dreq_take;
        dresp_seq_d = dresp_seq_q;
        dresp_ts_d = dresp_ts_q;
        if (dreq_take) begin
            dresp_seq_d = dreq_seq;
            dresp_ts_d = tb_now;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dresp_valid_q <= 1'b0;
            dresp_seq_q <= '0;
            dresp_ts_q <= '0;
        end else begin
            dresp_valid_q <= dresp_valid_d;
            dresp_seq_q <= dresp_seq_d;
            dresp_ts_q <= dresp_ts_d;
        end
    end

    // slave offset group
    logic offset_valid_d;
    logic signed [31:0] offset_ns_d;

    always_comb begin
        offset_valid_d = offset_req;
        offset_ns_d = offset_ns_q;
        if (offset_req) begin
            offset_ns_d = slave_offset(freq_mode, sync_delta_ns, path_delay_ns,
                                       cfg_q.static_asym_ns, corr_asym_ns);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            offset_valid_q <= 1'b0;
            offset_ns_q <= '0;
        end else begin
            offset_valid_q <= offset_valid_d;
            offset_ns_q <= offset_ns_d;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    chk_ann_frozen: assert property (!$past(cfg_update) |-> $stable(ann_q))
        else $error("announce fields changed without a config update");
    chk_nontai_flags: assert property (
        cfg_update && cfg_in.mode != ptp_announce_pkg::MODE_TAI |=>
        !ann_q.ptp_timescale && !ann_q.leap59 && !ann_q.leap61 && !ann_q.time_traceable)
        else $error("non-TAI announce flags not cleared");
    chk_nontai_freq: assert property (
        cfg_update && cfg_in.mode != ptp_announce_pkg::MODE_TAI |=>
        ann_q.freq_traceable && !ann_q.utc_valid)
        else $error("non-TAI frequency or utc validity wrong");
    chk_arb_class: assert property (
        cfg_update && cfg_in.mode == ptp_announce_pkg::MODE_ARB && !cfg_in.profile_en |=>
        ann_q.clock_class == 8'h0D && ann_q.time_source == $past(cfg_in.time_source))
        else $error("arbitrary mode class or source wrong");
    chk_freq_source: assert property (
        cfg_update && cfg_in.mode == ptp_announce_pkg::MODE_FREQ |=>
        ann_q.time_source == 8'hA0 && ann_q.clock_class == $past(cfg_in.clock_class))
        else $error("frequency mode source or class wrong");
    chk_tai_flags: assert property (
        cfg_update && cfg_in.mode == ptp_announce_pkg::MODE_TAI && !cfg_in.profile_en |=>
        ann_q.ptp_timescale && ann_q.time_traceable && ann_q.clock_class == 8'h06)
        else $error("TAI announce flags or class wrong");
    chk_dresp_match: assert property (
        dreq_valid && state_q == ST_MASTER && dreq_domain == domain_q |=>
        dresp_valid_q && dresp_seq_q == $past(dreq_seq))
        else $error("delay request without matching response");
    chk_foreign_domain: assert property (
        dreq_valid && dreq_domain != domain_q |=> !dresp_valid_q)
        else $error("response sent for foreign sub-domain");
    chk_rival_passive: assert property (
        state_q == ST_MASTER && rival_seen && !cfg_update |=> passive_q ##1 passive_q)
        else $error("rival master did not force passive state");
    chk_epoch_align: assert property (
        epoch_load && !freq_mode |=> ##1 event_ts_q.sec == $past(epoch_val.sec, 2))
        else $error("timebase not aligned to supplied epoch");
    chk_own_epoch: assert property (
        epoch_load && freq_mode && !ref_tick |=> $stable(tb_now))
        else $error("frequency mode accepted an external epoch");
    chk_arb_stamp: assert property (
        cfg_q.mode != ptp_announce_pkg::MODE_TAI |=> ts_arb_q)
        else $error("non-TAI timestamps not marked arbitrary");
    chk_offset_calc: assert property (
        offset_req |=> offset_valid_q && offset_ns_q ==
        $past(sync_delta_ns) - $past(cfg_q.static_asym_ns) - $past(corr_asym_ns)
        - ($past(freq_mode) ? 32'sh0 : $past(path_delay_ns)))
        else $error("slave offset arithmetic wrong");

    cov_arb_update: cover property (cfg_update && cfg_in.mode == ptp_announce_pkg::MODE_ARB);
    cov_passive: cover property (state_q == ST_MASTER ##1 state_q == ST_PASSIVE);
    cov_back_to_back: cover property (dresp_valid_q [*3]);
    cov_freq_offset: cover property (offset_req && freq_mode);

endmodule

// [pkg/ptp_announce_pkg.sv]
// Purpose: shared constants and types for the announce traceability selector
// Assumes: 20 MHz system clock, single clock domain
// Notes: configuration and message fields travel as packed structs
package ptp_announce_pkg;

    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned NS_PER_SEC = 1_000_000_000;

    // foreign master must stay silent this long before passive state is left
    localparam int unsigned PASSIVE_HOLD_MS = 3000;
    localparam int unsigned PASSIVE_HOLD_CYCLES = (CLK_HZ / 1000) * PASSIVE_HOLD_MS;

    localparam logic [7:0] CLASS_TAI_DEFAULT = 8'h06;
    localparam logic [7:0] CLASS_ARB_DEFAULT = 8'h0D;
    localparam logic [7:0] SRC_INTERNAL_OSC = 8'hA0;

    localparam logic [29:0] REF_STEP_RESET = 30'h0000_0032;
    localparam logic [7:0] DOMAIN_RESET = 8'h00;

    typedef enum logic [1:0] {
        MODE_TAI,
        MODE_ARB,
        MODE_FREQ
    } tb_mode_t;

    typedef struct packed {
        tb_mode_t mode;
        logic profile_en;
        logic [7:0] clock_class;
        logic [7:0] time_source;
        logic [15:0] utc_offset;
        logic leap59;
        logic leap61;
        logic [7:0] domain;
        logic signed [31:0] static_asym_ns;
        logic [29:0] ref_step_ns;
    } cfg_t;

    typedef struct packed {
        logic ptp_timescale;
        logic leap59;
        logic leap61;
        logic time_traceable;
        logic freq_traceable;
        logic utc_valid;
        logic [15:0] utc_offset;
        logic [7:0] time_source;
        logic [7:0] clock_class;
    } ann_t;

    typedef struct packed {
        logic [47:0] sec;
        logic [29:0] ns;
    } ts_t;

endpackage

// [rtl/timebase_counter.sv]
// Purpose: seconds/nanoseconds timebase advanced by reference ticks
// Assumes: ref_tick is a one-cycle enable, step below one second
// Notes: load has priority over the tick in the same cycle
`timescale 1ns/10ps
module timebase_counter (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ref_tick,
    input wire logic [29:0] step_ns,
    input wire logic load,
    input wire ptp_announce_pkg::ts_t load_val,
    output ptp_announce_pkg::ts_t tb_q
);
    localparam logic [30:0] NS_WRAP = 31'(ptp_announce_pkg::NS_PER_SEC);

    ptp_announce_pkg::ts_t tb_d;
    logic [30:0] ns_sum;

    always_comb begin
        tb_d = tb_q;
        ns_sum = {1'b0, tb_q.ns} + {1'b0, step_ns};
        if (load) begin
            tb_d = load_val;
        end else if (ref_tick) begin
            if (ns_sum >= NS_WRAP) begin
                tb_d.ns = 30'(ns_sum - NS_WRAP);
                tb_d.sec = tb_q.sec + 48'h0000_0000_0001;
            end else begin
                tb_d.ns = ns_sum[29:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tb_q <= '0;
        end else begin
            tb_q <= tb_d;
        end
    end

endmodule

// [verification/slave_population.sv]
// Purpose: population of slave clocks facing the grandmaster block
// Assumes: callers enter each task just after a rising clk_sys edge
// Notes: released lines show inverted data, never the last value
`timescale 1ns/10ps
module slave_population (
    input wire logic clk_sys,
    output logic dreq_valid,
    output logic [7:0] dreq_domain,
    output logic [15:0] dreq_seq,
    output logic foreign_ann_valid,
    output logic [7:0] foreign_domain
);
    initial begin
        dreq_valid = 1'b0;
        dreq_domain = 8'h00;
        dreq_seq = 16'h0000;
        foreign_ann_valid = 1'b0;
        foreign_domain = 8'h00;
    end

    // each call drives one request; the strobe stays high through later calls until go_idle
    task automatic send_req(input logic [7:0] dom, input logic [15:0] seq);
        dreq_valid <= 1'b1;
        dreq_domain <= dom;
        dreq_seq <= seq;
    endtask

    task automatic send_rival(input logic [7:0] dom);
        foreign_ann_valid <= 1'b1;
        foreign_domain <= dom;
    endtask

    // stale fields would hide a design that samples them outside the strobe
    task automatic go_idle();
        dreq_valid <= 1'b0;
        dreq_domain <= ~dreq_domain;
        dreq_seq <= ~dreq_seq;
        foreign_ann_valid <= 1'b0;
        foreign_domain <= ~foreign_domain;
    endtask
endmodule

// [verification/tb_top.sv]
// Purpose: self-checking bench for the announce traceability selector
// Assumes: all stimulus lands on rising edges; checks 1 ns after an edge
// Notes: passive hold shortened to 20 cycles to keep the run brief
`timescale 1ns/10ps
module tb_top;
    localparam int unsigned PCYC = 20;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_update = 1'b0, ref_tick = 1'b0, epoch_load = 1'b0, offset_req = 1'b0;
    ptp_announce_pkg::cfg_t cfg_in = '0;
    ptp_announce_pkg::cfg_t cur = '0;
    ptp_announce_pkg::ts_t epoch_val = '0;
    logic dreq_valid, foreign_ann_valid;
    logic [7:0] dreq_domain, foreign_domain, domain_q;
    logic [15:0] dreq_seq, dresp_seq_q;
    logic signed [31:0] sync_delta_ns = '0, path_delay_ns = '0, corr_asym_ns = '0, offset_ns_q;
    ptp_announce_pkg::ann_t ann_q;
    ptp_announce_pkg::ts_t event_ts_q, dresp_ts_q;
    logic passive_q, ts_arb_q, dresp_valid_q, offset_valid_q;
    int failures = 0, cmp_count = 0, cycles = 0, seed = 57;
    logic [15:0] seqs[$];
    logic [7:0] dom;
    logic signed [31:0] exp_off;
    int wait_n;

    always #25 clk_sys = ~clk_sys;

    ptp_announce_traceability_select #(.PASSIVE_CYCLES(PCYC)) u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .cfg_in(cfg_in), .cfg_update(cfg_update),
        .ref_tick(ref_tick), .epoch_load(epoch_load), .epoch_val(epoch_val),
        .foreign_ann_valid(foreign_ann_valid), .foreign_domain(foreign_domain),
        .dreq_valid(dreq_valid), .dreq_domain(dreq_domain), .dreq_seq(dreq_seq),
        .offset_req(offset_req), .sync_delta_ns(sync_delta_ns), .path_delay_ns(path_delay_ns),
        .corr_asym_ns(corr_asym_ns), .ann_q(ann_q), .domain_q(domain_q), .passive_q(passive_q),
        .event_ts_q(event_ts_q), .ts_arb_q(ts_arb_q), .dresp_valid_q(dresp_valid_q),
        .dresp_seq_q(dresp_seq_q), .dresp_ts_q(dresp_ts_q), .offset_valid_q(offset_valid_q),
        .offset_ns_q(offset_ns_q)
    );

    slave_population u_slaves (
        .clk_sys(clk_sys), .dreq_valid(dreq_valid), .dreq_domain(dreq_domain),
        .dreq_seq(dreq_seq), .foreign_ann_valid(foreign_ann_valid),
        .foreign_domain(foreign_domain)
    );

    task automatic print_verdict();
        if (failures == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic chk(input logic [77:0] got, input logic [77:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // announce contents worked out from the configuration alone
    function automatic ptp_announce_pkg::ann_t exp_ann(input ptp_announce_pkg::cfg_t c);
        ptp_announce_pkg::ann_t a;
        a = '0;
        a.freq_traceable = 1'b1;
        a.time_source = c.time_source;
        a.clock_class = c.clock_class;
        if (c.mode == ptp_announce_pkg::MODE_TAI) begin
            a.ptp_timescale = 1'b1;
            a.time_traceable = 1'b1;
            a.leap59 = c.leap59;
            a.leap61 = c.leap61;
            a.utc_valid = 1'b1;
            a.utc_offset = c.utc_offset;
            if (!c.profile_en) a.clock_class = 8'h06;
        end else if (c.mode == ptp_announce_pkg::MODE_FREQ) begin
            a.time_source = ptp_announce_pkg::SRC_INTERNAL_OSC;
        end else if (!c.profile_en) begin
            a.clock_class = 8'h0D;
        end
        return a;
    endfunction

    // offset field is meaningless once marked invalid, so it is masked
    task automatic chk_ann();
        ptp_announce_pkg::ann_t g;
        g = ann_q;
        if (cur.mode != ptp_announce_pkg::MODE_TAI) g.utc_offset = '0;
        chk(78'(g), 78'(exp_ann(cur)));
    endtask

    task automatic apply_cfg(input ptp_announce_pkg::tb_mode_t m, input logic prof);
        ptp_announce_pkg::cfg_t c;
        logic [127:0] rnd;
        rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
        c = rnd[$bits(ptp_announce_pkg::cfg_t)-1:0];
        c.mode = m;
        c.profile_en = prof;
        c.ref_step_ns = 30'(20 + ($random(seed) & 63));
        @(posedge clk_sys);
        cfg_in <= c;
        cfg_update <= 1'b1;
        @(posedge clk_sys);
        cfg_update <= 1'b0;
        @(posedge clk_sys);
        #1;
        cur = c;
        chk_ann();
        chk(78'(domain_q), 78'(c.domain));
        @(posedge clk_sys);
        #1;
        chk(78'(ts_arb_q), 78'(m != ptp_announce_pkg::MODE_TAI));
    endtask

    task automatic tick_n(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            ref_tick <= 1'b1;
        end
        @(posedge clk_sys);
        ref_tick <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    // a tick beside the load shows which of the two wins
    task automatic load_epoch(input ptp_announce_pkg::ts_t v, input logic tk);
        @(posedge clk_sys);
        epoch_val <= v;
        epoch_load <= 1'b1;
        ref_tick <= tk;
        @(posedge clk_sys);
        epoch_load <= 1'b0;
        ref_tick <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic run_offset();
        @(posedge clk_sys);
        sync_delta_ns <= $random(seed);
        path_delay_ns <= $random(seed) & 32'h0000FFFF;
        corr_asym_ns <= $random(seed) % 500;
        offset_req <= 1'b1;
        @(posedge clk_sys);
        offset_req <= 1'b0;
        exp_off = sync_delta_ns - cur.static_asym_ns - corr_asym_ns;
        if (cur.mode != ptp_announce_pkg::MODE_FREQ) exp_off = exp_off - path_delay_ns;
        #1;
        chk(78'(offset_valid_q), 78'(1));
        chk(78'(offset_ns_q), 78'(exp_off));
    endtask

    initial begin
        ptp_announce_pkg::ts_t v;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk(78'(ann_q), 78'({5'h01, 17'h0, 8'hA0, 8'h00}));
        chk(78'({domain_q, passive_q, ts_arb_q}), 78'(10'h001));
        tick_n(5);
        chk(78'(event_ts_q), 78'(5 * 50));
        v = '{sec: 48'h0000_1234_5678, ns: 30'd999_000_000};
        load_epoch(v, 1'b1);
        chk(78'(event_ts_q), 78'(5 * 50 + 50));
        seqs.delete();
        for (int m = 0; m < 3; m++) begin
            for (int p = 0; p < 2; p++) begin
                apply_cfg(ptp_announce_pkg::tb_mode_t'(m), p[0]);
                run_offset();
            end
        end
        @(posedge clk_sys);
        cfg_in <= ~cur;
        repeat (3) @(posedge clk_sys);
        #1;
        chk_ann();
        apply_cfg(ptp_announce_pkg::MODE_ARB, 1'b0);
        v.ns = 30'd1_000_000_000 - 30'(cur.ref_step_ns);
        load_epoch(v, 1'b1);
        chk(78'(event_ts_q), 78'(v));
        tick_n(3);
        v.sec = v.sec + 48'h1;
        v.ns = 30'(2 * cur.ref_step_ns);
        chk(78'(event_ts_q), 78'(v));
        dom = cur.domain;
        for (int i = 0; i < 7; i++) begin
            @(posedge clk_sys);
            if (i < 4) begin
                seqs.push_back(16'($random(seed)));
                u_slaves.send_req(dom, seqs[i]);
            end else if (i == 4) begin
                u_slaves.send_req(~dom, 16'h5A5A);
            end else begin
                u_slaves.go_idle();
            end
            #1;
            if (i >= 1) chk(78'(dresp_valid_q), 78'(i < 5));
            if (i >= 1 && i < 5) chk(78'(dresp_seq_q), 78'(seqs[i - 1]));
        end
        chk(78'(dresp_ts_q), 78'(v));
        @(posedge clk_sys);
        u_slaves.send_rival(dom);
        @(posedge clk_sys);
        u_slaves.send_req(dom, 16'h1357);
        @(posedge clk_sys);
        u_slaves.go_idle();
        #1;
        chk(78'(passive_q), 78'(1));
        chk(78'(dresp_valid_q), 78'(0));
        wait_n = 0;
        while (passive_q === 1'b1 && wait_n < 3 * PCYC) begin
            @(posedge clk_sys);
            #1;
            wait_n++;
        end
        chk(78'(passive_q), 78'(0));
        @(posedge clk_sys);
        u_slaves.send_rival(~dom);
        @(posedge clk_sys);
        u_slaves.go_idle();
        @(posedge clk_sys);
        #1;
        chk(78'(passive_q), 78'(0));
        apply_cfg(ptp_announce_pkg::MODE_FREQ, 1'b1);
        v = '{sec: 48'h0000_0000_0ABC, ns: 30'd7};
        load_epoch(v, 1'b0);
        chk(78'(event_ts_q == v), 78'(0));
        print_verdict();
    end
endmodule
